// ==== hw/uctl_consts.svh ====
`ifndef UCTL_CONSTS_SVH
`define UCTL_CONSTS_SVH

// ------
// Register map, per channel; channel B sits one channel stride higher.
// ------
`define UCTL_ADDR_W       8
`define UCTL_CHAN_BIT     6
`define UCTL_HOLE_BIT     5
`define UCTL_HOLE_BIT2    7
`define UCTL_IDX_FIFO_CTL 3'h0
`define UCTL_IDX_INT_STAT 3'h1
`define UCTL_IDX_ENH_CTL  3'h2
`define UCTL_IDX_RX_LVL   3'h3
`define UCTL_IDX_TX_LVL   3'h4
`define UCTL_IDX_FLOW_LO  3'h5
`define UCTL_IDX_FLOW_HI  3'h6
`define UCTL_IDX_COUNTS   3'h7

// ------
// Field positions.
// ------
`define UCTL_FCR_EN_BIT   0
`define UCTL_FCR_RXCLR    1
`define UCTL_FCR_TXCLR    2
`define UCTL_FCR_DMA_BIT  3
`define UCTL_FCR_TXT_LSB  4
`define UCTL_FCR_RXT_LSB  6
`define UCTL_EFR_ENH_BIT  4

// ------
// Trigger tables, FIFO depth, interrupt codes and bus answers.
// ------
`define UCTL_FIFO_DEPTH   8'h20
`define UCTL_RX_TRIG_00   8'h08
`define UCTL_RX_TRIG_01   8'h10
`define UCTL_RX_TRIG_10   8'h18
`define UCTL_RX_TRIG_11   8'h1c
`define UCTL_TX_TRIG_00   8'h10
`define UCTL_TX_TRIG_01   8'h08
`define UCTL_TX_TRIG_10   8'h18
`define UCTL_TX_TRIG_11   8'h1e
`define UCTL_CODE_LINE    6'h06
`define UCTL_CODE_RXDATA  6'h04
`define UCTL_CODE_RXTMO   6'h0c
`define UCTL_CODE_THR     6'h02
`define UCTL_CODE_MODEM   6'h00
`define UCTL_CODE_XOFF    6'h10
`define UCTL_CODE_FLOW    6'h20
`define UCTL_CODE_NONE    6'h01
`define UCTL_RESP_OKAY    2'h0
`define UCTL_RESP_SLVERR  2'h2

`endif

// ==== hw/uctl_pkg.sv ====
package uctl_pkg;

  // Interrupt sources, in falling priority order.
  typedef enum logic [2:0] {
    SRC_LINE   = 3'h0,
    SRC_RXDATA = 3'h1,
    SRC_RXTMO  = 3'h3,
    SRC_THR    = 3'h2,
    SRC_MODEM  = 3'h6,
    SRC_XOFF   = 3'h7,
    SRC_FLOW   = 3'h5,
    SRC_NONE   = 3'h4
  } uctl_src_idx_type;

  // Per-channel status arriving from the FIFO and line logic.
  typedef struct packed {
    logic [7:0] rx_count;
    logic [7:0] tx_count;
    logic       line_status_int;
    logic       rx_timeout;
    logic       modem_status_int;
    logic       xoff_rx;
    logic       xon_rx;
    logic       flow_change;
  } uctl_src_type;

  typedef struct packed {
    logic             fifo_en;
    logic             dma_mode1;
    logic [1:0]       rx_trig_sel;
    logic [1:0]       tx_trig_sel;
    logic [7:0]       enhanced_feature_ctl;
    logic [7:0]       rx_lvl;
    logic [7:0]       tx_lvl;
    logic [7:0]       flow_lo;
    logic [7:0]       flow_hi;
    uctl_src_idx_type src_idx;
    logic             thr_int;
    logic             flow_int;
    logic             xoff_flag;
    logic             tx_empty_prev;
    logic             tx_pin;
    logic             rx_pin;
    logic             tx_clr;
    logic             rx_clr;
  } uctl_chan_type;

  typedef struct packed {
    logic                    aw_rdy;
    logic                    w_rdy;
    logic                    ar_rdy;
    logic [7:0]              aw_addr;
    logic [7:0]              wdata;
    logic                    wen;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    rvalid;
    logic [1:0]              rresp;
    logic [31:0]             rdata;
    uctl_chan_type [1:0]     ch;
  } uctl_state_type;

endpackage

// ==== hw/uctl_top.sv ====
`timescale 1ns/10ps
`include "uctl_consts.svh"
// Summary of operation
// (RULE1) Mode 1: tx ready pin high when tx FIFO full, low at trigger.
// (RULE2) Mode 1: rx ready pin low at rx trigger or time-out.
// (RULE3) Mode 1: rx ready pin returns high only once rx FIFO empty.
// (RULE4) Writing one to tx FIFO reset clears tx FIFO; bit self-clears.
// (RULE5) Writing one to rx FIFO reset clears rx FIFO; bit self-clears.
// (RULE6) FIFO enable bit enables both FIFOs; disabled after reset.
// (RULE7) Rx trigger field codes 00..11 select 8, 16, 24, 28 bytes.
// (RULE8) Tx trigger field codes 00..11 select 16, 8, 24, 30 bytes.
// (RULE9) Any nonzero level register makes triggers come from level registers.
// (RULE10) Six priority levels; status read returns highest pending code.
// (RULE11) Pending interrupt held until serviced; then lower one may appear.
// (RULE12) Line status interrupt: priority 1, code 000110.
// (RULE13) Priority 2: data ready code 000100, time-out code 001100.
// (RULE14) Transmit holding empty: priority 3, code 000010.
// (RULE15) Modem status change: priority 4, code 000000.
// (RULE16) Xoff or special character: priority 5, only bit 4 set.
// (RULE17) Flow-control line change: priority 6, only bit 5 set.
// (RULE18) Status bits 7:6 read one with FIFOs enabled, else zero.
// (RULE19) Status bits 5:4 only while enhanced enable bit set.
// (RULE20) Xoff-detected bit stays set until Xon characters arrive.
// (RULE21) Status bit 0 is zero while pending, one otherwise; resets to one.
// (RULE22) Mode 0: tx ready pin low while tx FIFO empty, high once loaded.
// (RULE23) Mode 0: rx ready pin low while data held, high when empty.
// (RULE24) Each channel has its own independent registers and pins.
// (RULE25) Host services the reported source before expecting a lower one.
module uctl_top (
  // Clock and reset.
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // AXI4-Lite write address and data.
  input  wire logic [`UCTL_ADDR_W-1:0]       s_awaddr,
  input  wire logic                          s_awvalid,
  output logic                               s_awready,
  input  wire logic [31:0]                   s_wdata,
  input  wire logic [3:0]                    s_wstrb,
  input  wire logic                          s_wvalid,
  output logic                               s_wready,
  // AXI4-Lite write response.
  output logic [1:0]                         s_bresp,
  output logic                               s_bvalid,
  input  wire logic                          s_bready,
  // AXI4-Lite read.
  input  wire logic [`UCTL_ADDR_W-1:0]       s_araddr,
  input  wire logic                          s_arvalid,
  output logic                               s_arready,
  output logic [31:0]                        s_rdata,
  output logic [1:0]                         s_rresp,
  output logic                               s_rvalid,
  input  wire logic                          s_rready,
  // Channel status from the FIFO and line logic, index 0 is channel A.
  input  wire uctl_pkg::uctl_src_type [1:0]  chan_src,
  // FIFO clear pulses, one cycle, index 0 is channel A.
  output logic [1:0]                         tx_fifo_clear,
  output logic [1:0]                         rx_fifo_clear,
  // DMA pacing pins.
  output logic                               tx_ready_pin_chan_a,
  output logic                               tx_ready_pin_chan_b,
  output logic                               rx_ready_pin_chan_a,
  output logic                               rx_ready_pin_chan_b
);
  import uctl_pkg::*;

  uctl_state_type st_q;
  uctl_state_type st_d;

  // ------
  // Decode helpers.
  // ------

  // Address decode: bit 0 valid, bit 1 channel, bits 4:2 register index.
  function automatic logic [4:0] decode(logic [`UCTL_ADDR_W-1:0] a);
    return {a[4:2], a[`UCTL_CHAN_BIT], ~a[`UCTL_HOLE_BIT] & ~a[`UCTL_HOLE_BIT2]};
  endfunction

  // Trigger pair {rx, tx}; the level registers override the tables.
  function automatic logic [15:0] pick_trig(uctl_chan_type ch);
    logic [7:0] rx_t;
    logic [7:0] tx_t;
    rx_t = '0;
    tx_t = '0;
    if (|{ch.rx_lvl, ch.tx_lvl, ch.flow_lo, ch.flow_hi}) begin // RULE9
      rx_t = ch.rx_lvl;
      tx_t = ch.tx_lvl;
    end else begin
      unique case (ch.rx_trig_sel) // RULE7
        2'b00: rx_t = `UCTL_RX_TRIG_00;
        2'b01: rx_t = `UCTL_RX_TRIG_01;
        2'b10: rx_t = `UCTL_RX_TRIG_10;
        2'b11: rx_t = `UCTL_RX_TRIG_11;
      endcase
      unique case (ch.tx_trig_sel) // RULE8
        2'b00: tx_t = `UCTL_TX_TRIG_00;
        2'b01: tx_t = `UCTL_TX_TRIG_01;
        2'b10: tx_t = `UCTL_TX_TRIG_10;
        2'b11: tx_t = `UCTL_TX_TRIG_11;
      endcase
    end
    return {rx_t, tx_t};
  endfunction

  // Status code of a latched source, bits 5:0.
  function automatic logic [5:0] code_of(uctl_src_idx_type idx);
    logic [5:0] c;
    c = `UCTL_CODE_NONE;
    unique case (idx)
      SRC_LINE:   c = `UCTL_CODE_LINE;   // RULE12
      SRC_RXDATA: c = `UCTL_CODE_RXDATA; // RULE13
      SRC_RXTMO:  c = `UCTL_CODE_RXTMO;  // RULE13
      SRC_THR:    c = `UCTL_CODE_THR;    // RULE14
      SRC_MODEM:  c = `UCTL_CODE_MODEM;  // RULE15
      SRC_XOFF:   c = `UCTL_CODE_XOFF;   // RULE16
      SRC_FLOW:   c = `UCTL_CODE_FLOW;   // RULE17
      SRC_NONE:   c = `UCTL_CODE_NONE;   // RULE21
    endcase
    return c;
  endfunction

  // Highest pending source; bit 0 of the vector is the most urgent.
  function automatic uctl_src_idx_type highest(logic [6:0] p);
    uctl_src_idx_type r;
    r = SRC_NONE;
    if (p[0]) begin // RULE10
      r = SRC_LINE;
    end else if (p[1]) begin
      r = SRC_RXDATA;
    end else if (p[2]) begin
      r = SRC_RXTMO;
    end else if (p[3]) begin
      r = SRC_THR;
    end else if (p[4]) begin
      r = SRC_MODEM;
    end else if (p[5]) begin
      r = SRC_XOFF;
    end else if (p[6]) begin
      r = SRC_FLOW;
    end
    return r;
  endfunction

  // Pending bit of a given source within the vector.
  function automatic logic is_pending(uctl_src_idx_type idx, logic [6:0] p);
    logic r;
    r = 1'b0;
    unique case (idx)
      SRC_LINE:   r = p[0];
      SRC_RXDATA: r = p[1];
      SRC_RXTMO:  r = p[2];
      SRC_THR:    r = p[3];
      SRC_MODEM:  r = p[4];
      SRC_XOFF:   r = p[5];
      SRC_FLOW:   r = p[6];
      SRC_NONE:   r = 1'b0;
    endcase
    return r;
  endfunction

  // Interrupt status byte as software sees it.
  function automatic logic [7:0] status_byte(uctl_chan_type ch);
    logic [5:0] c;
    c = code_of(ch.src_idx);
    c[5:4] = c[5:4] & {2{ch.enhanced_feature_ctl[`UCTL_EFR_ENH_BIT]}}; // RULE19
    return {{2{ch.fifo_en}}, c}; // RULE18
  endfunction

  // ------
  // Next-state logic.
  // ------

  // The bus is served first so that a status read can clear flags;
  // the channel logic runs afterwards so that a new event wins.
  always_comb begin
    logic [4:0]  wdec;
    logic [4:0]  rdec;
    logic [1:0]  isr_rd;
    logic [7:0]  rd_byte;
    logic [15:0] trig;
    logic [7:0]  rx_tr;
    logic [7:0]  tx_tr;
    logic [6:0]  pend;
    logic        tx_empty;
    logic        efr4;
    uctl_src_type s;
    wdec    = decode(st_q.aw_addr);
    rdec    = decode(s_araddr);
    isr_rd  = '0;
    rd_byte = '0;
    trig    = '0;
    rx_tr   = '0;
    tx_tr   = '0;
    pend    = '0;
    tx_empty = 1'b0;
    efr4    = 1'b0;
    s       = '0;
    st_d    = st_q;
    for (int c = 0; c < 2; c++) begin
      st_d.ch[c].tx_clr = 1'b0;
      st_d.ch[c].rx_clr = 1'b0;
    end

    // Write channels: address and data are taken independently.
    if (st_q.aw_rdy && s_awvalid) begin
      st_d.aw_rdy  = 1'b0;
      st_d.aw_addr = s_awaddr;
    end
    if (st_q.w_rdy && s_wvalid) begin
      st_d.w_rdy = 1'b0;
      st_d.wdata = s_wdata[7:0];
      st_d.wen   = s_wstrb[0];
    end
    if (!st_q.aw_rdy && !st_q.w_rdy && !st_q.bvalid) begin
      st_d.bvalid = 1'b1;
      st_d.bresp  = wdec[0] ? `UCTL_RESP_OKAY : `UCTL_RESP_SLVERR;
      if (wdec[0] && st_q.wen) begin
        unique case (wdec[4:2])
          `UCTL_IDX_FIFO_CTL: begin
            st_d.ch[wdec[1]].fifo_en     = st_q.wdata[`UCTL_FCR_EN_BIT]; // RULE6
            st_d.ch[wdec[1]].rx_clr      = st_q.wdata[`UCTL_FCR_RXCLR];  // RULE5
            st_d.ch[wdec[1]].tx_clr      = st_q.wdata[`UCTL_FCR_TXCLR];  // RULE4
            st_d.ch[wdec[1]].dma_mode1   = st_q.wdata[`UCTL_FCR_DMA_BIT];
            st_d.ch[wdec[1]].tx_trig_sel = st_q.wdata[`UCTL_FCR_TXT_LSB +: 2];
            st_d.ch[wdec[1]].rx_trig_sel = st_q.wdata[`UCTL_FCR_RXT_LSB +: 2];
          end
          `UCTL_IDX_ENH_CTL: st_d.ch[wdec[1]].enhanced_feature_ctl     = st_q.wdata;
          `UCTL_IDX_RX_LVL:  st_d.ch[wdec[1]].rx_lvl  = st_q.wdata;
          `UCTL_IDX_TX_LVL:  st_d.ch[wdec[1]].tx_lvl  = st_q.wdata;
          `UCTL_IDX_FLOW_LO: st_d.ch[wdec[1]].flow_lo = st_q.wdata;
          `UCTL_IDX_FLOW_HI: st_d.ch[wdec[1]].flow_hi = st_q.wdata;
          default: ; // Status and count words ignore writes.
        endcase
      end
    end
    if (st_q.bvalid && s_bready) begin
      st_d.bvalid = 1'b0;
      st_d.aw_rdy = 1'b1;
      st_d.w_rdy  = 1'b1;
    end

    // Read channel: one word answered the cycle after the address.
    if (st_q.ar_rdy && s_arvalid) begin
      if (rdec[0]) begin
        unique case (rdec[4:2])
          `UCTL_IDX_FIFO_CTL: rd_byte = {st_q.ch[rdec[1]].rx_trig_sel,
                                         st_q.ch[rdec[1]].tx_trig_sel,
                                         st_q.ch[rdec[1]].dma_mode1, 2'b00,
                                         st_q.ch[rdec[1]].fifo_en};
          `UCTL_IDX_INT_STAT: begin
            rd_byte        = status_byte(st_q.ch[rdec[1]]); // RULE10
            isr_rd[rdec[1]] = 1'b1;
          end
          `UCTL_IDX_ENH_CTL: rd_byte = st_q.ch[rdec[1]].enhanced_feature_ctl;
          `UCTL_IDX_RX_LVL:  rd_byte = st_q.ch[rdec[1]].rx_lvl;
          `UCTL_IDX_TX_LVL:  rd_byte = st_q.ch[rdec[1]].tx_lvl;
          `UCTL_IDX_FLOW_LO: rd_byte = st_q.ch[rdec[1]].flow_lo;
          `UCTL_IDX_FLOW_HI: rd_byte = st_q.ch[rdec[1]].flow_hi;
          `UCTL_IDX_COUNTS:  rd_byte = '0;
        endcase
      end
      st_d.ar_rdy = 1'b0;
      st_d.rvalid = 1'b1;
      st_d.rresp  = rdec[0] ? `UCTL_RESP_OKAY : `UCTL_RESP_SLVERR;
      st_d.rdata  = {24'h000000, rd_byte};
      if (rdec[0] && rdec[4:2] == `UCTL_IDX_COUNTS) begin
        st_d.rdata = {16'h0000, chan_src[rdec[1]].rx_count,
                      chan_src[rdec[1]].tx_count};
      end
    end
    if (st_q.rvalid && s_rready) begin
      st_d.rvalid = 1'b0;
      st_d.ar_rdy = 1'b1;
    end

    // Per-channel interrupt and pin logic; channels share nothing.
    for (int c = 0; c < 2; c++) begin // RULE24
      s        = chan_src[c];
      trig     = pick_trig(st_q.ch[c]);
      rx_tr    = trig[15:8];
      tx_tr    = trig[7:0];
      efr4     = st_q.ch[c].enhanced_feature_ctl[`UCTL_EFR_ENH_BIT];
      tx_empty = (s.tx_count == 8'h00);
      st_d.ch[c].tx_empty_prev = tx_empty;

      // Reading the status clears the reported one-shot source.
      if (isr_rd[c] && st_q.ch[c].src_idx == SRC_THR) begin
        st_d.ch[c].thr_int = 1'b0;
      end
      if (isr_rd[c] && st_q.ch[c].src_idx == SRC_FLOW) begin
        st_d.ch[c].flow_int = 1'b0;
      end
      if (!tx_empty) begin
        st_d.ch[c].thr_int = 1'b0;
      end
      if (s.xon_rx) begin
        st_d.ch[c].xoff_flag = 1'b0; // RULE20
      end
      // Sets come last so an event on a clearing cycle is kept.
      if (tx_empty && !st_q.ch[c].tx_empty_prev) begin
        st_d.ch[c].thr_int = 1'b1;
      end
      if (s.flow_change) begin
        st_d.ch[c].flow_int = 1'b1;
      end
      if (s.xoff_rx) begin
        st_d.ch[c].xoff_flag = 1'b1; // RULE20
      end

      pend[0] = s.line_status_int;
      pend[1] = st_q.ch[c].fifo_en ? (s.rx_count >= rx_tr) : (s.rx_count != 8'h00);
      pend[2] = s.rx_timeout;
      pend[3] = st_q.ch[c].thr_int;
      pend[4] = s.modem_status_int;
      pend[5] = efr4 & st_q.ch[c].xoff_flag; // RULE19
      pend[6] = efr4 & st_q.ch[c].flow_int;  // RULE19
      // The latched source stands until it is no longer pending.
      if (!is_pending(st_q.ch[c].src_idx, pend)) begin // RULE11
        st_d.ch[c].src_idx = highest(pend); // RULE10
      end

      // DMA pacing pins hold their level between the switching points.
      if (st_q.ch[c].fifo_en && st_q.ch[c].dma_mode1) begin
        if (s.tx_count >= `UCTL_FIFO_DEPTH) begin
          st_d.ch[c].tx_pin = 1'b1; // RULE1
        end else if (s.tx_count <= tx_tr) begin
          st_d.ch[c].tx_pin = 1'b0; // RULE1
        end
        if ((s.rx_count >= rx_tr && s.rx_count != 8'h00) || s.rx_timeout) begin
          st_d.ch[c].rx_pin = 1'b0; // RULE2
        end else if (s.rx_count == 8'h00) begin
          st_d.ch[c].rx_pin = 1'b1; // RULE3
        end
      end else begin
        st_d.ch[c].tx_pin = !tx_empty;              // RULE22
        st_d.ch[c].rx_pin = (s.rx_count == 8'h00); // RULE23
      end
    end
  end

  // ------
  // State register.
  // ------

  // Reset leaves both FIFOs disabled and no interrupt pending.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q        <= '0;
      st_q.aw_rdy <= 1'b1;
      st_q.w_rdy  <= 1'b1;
      st_q.ar_rdy <= 1'b1;
      for (int c = 0; c < 2; c++) begin
        st_q.ch[c].src_idx       <= SRC_NONE; // RULE21
        st_q.ch[c].tx_empty_prev <= 1'b1;
        st_q.ch[c].rx_pin        <= 1'b1;
      end
    end else begin
      st_q <= st_d;
    end
  end

  // ------
  // Outputs, all taken straight from the state register.
  // ------

  // Bus handshake and answers.
  assign s_awready = st_q.aw_rdy;
  assign s_wready  = st_q.w_rdy;
  assign s_bvalid  = st_q.bvalid;
  assign s_bresp   = st_q.bresp;
  assign s_arready = st_q.ar_rdy;
  assign s_rvalid  = st_q.rvalid;
  assign s_rresp   = st_q.rresp;
  assign s_rdata   = st_q.rdata;

  // Clear pulses per channel; the FIFO logic empties and rewinds its counters.
  for (genvar g = 0; g < 2; g++) begin : g_clr
    assign tx_fifo_clear[g] = st_q.ch[g].tx_clr;
    assign rx_fifo_clear[g] = st_q.ch[g].rx_clr;
  end

  // DMA pacing pins.
  assign tx_ready_pin_chan_a = st_q.ch[0].tx_pin;
  assign tx_ready_pin_chan_b = st_q.ch[1].tx_pin;
  assign rx_ready_pin_chan_a = st_q.ch[0].rx_pin;
  assign rx_ready_pin_chan_b = st_q.ch[1].rx_pin;

endmodule

// ==== dv/uctl_checker.sv ====
`timescale 1ns/10ps
// ------
// Port-level checker for channel A pacing pins and control writes.
// ------
module uctl_checker (
  // Clock and reset.
  input wire logic                         aclk,
  input wire logic                         aresetn,
  // Register bus.
  input wire logic [7:0]                   s_awaddr,
  input wire logic                         s_awvalid,
  input wire logic                         s_awready,
  input wire logic [31:0]                  s_wdata,
  input wire logic [3:0]                   s_wstrb,
  input wire logic                         s_wvalid,
  input wire logic                         s_wready,
  input wire logic [7:0]                   s_araddr,
  input wire logic                         s_arvalid,
  input wire logic                         s_arready,
  input wire logic [31:0]                  s_rdata,
  input wire logic                         s_rvalid,
  // Sources, clears and pins.
  input wire uctl_pkg::uctl_src_type [1:0] chan_src,
  input wire logic [1:0]                   tx_fifo_clear,
  input wire logic [1:0]                   rx_fifo_clear,
  input wire logic                         tx_ready_pin_chan_a,
  input wire logic                         rx_ready_pin_chan_a
);
  import uctl_pkg::*;
  logic [7:0] fc_q;
  logic [7:0] ar_q;
  logic       fc_wr;
  logic       m1;
  // Address and data are offered together, so one edge sees a whole write.
  assign fc_wr = s_awvalid && s_awready && s_wvalid && s_wready
                 && s_awaddr == 8'h00 && s_wstrb[0];
  assign m1 = fc_q[0] && fc_q[3];
  // Mirrors of the channel A control byte and the last read address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fc_q <= 8'h00;
      ar_q <= 8'h00;
    end else begin
      if (fc_wr) fc_q <= s_wdata[7:0];
      if (s_arvalid && s_arready) ar_q <= s_araddr;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_tx_clr;
    fc_wr && s_wdata[2] |-> ##[1:3] (tx_fifo_clear[0] ##1 !tx_fifo_clear[0]);
  endproperty
  a_tx_clr: assert property (p_tx_clr) else $error("tx clear pulse missing");
  property p_rx_clr;
    fc_wr && s_wdata[1] |-> ##[1:3] (rx_fifo_clear[0] ##1 !rx_fifo_clear[0]);
  endproperty
  a_rx_clr: assert property (p_rx_clr) else $error("rx clear pulse missing");
  property p_m0_tx;
    (!m1 && $stable(fc_q) && $stable(chan_src[0].tx_count))[*3]
      |-> tx_ready_pin_chan_a == (chan_src[0].tx_count != 8'h00);
  endproperty
  a_m0_tx: assert property (p_m0_tx) else $error("mode 0 tx pin wrong");
  property p_m0_rx;
    (!m1 && $stable(fc_q) && $stable(chan_src[0].rx_count))[*3]
      |-> rx_ready_pin_chan_a == (chan_src[0].rx_count == 8'h00);
  endproperty
  a_m0_rx: assert property (p_m0_rx) else $error("mode 0 rx pin wrong");
  property p_m1_full;
    (m1 && chan_src[0].tx_count >= 8'h20 && $stable(fc_q))[*3] |-> tx_ready_pin_chan_a;
  endproperty
  a_m1_full: assert property (p_m1_full) else $error("full tx FIFO not flagged");
  property p_m1_tmo;
    (m1 && chan_src[0].rx_timeout && $stable(fc_q))[*2] |-> !rx_ready_pin_chan_a;
  endproperty
  a_m1_tmo: assert property (p_m1_tmo) else $error("time-out not flagged");
  property p_m1_empty;
    (m1 && chan_src[0].rx_count == 8'h00 && !chan_src[0].rx_timeout && $stable(fc_q))[*3]
      |-> rx_ready_pin_chan_a;
  endproperty
  a_m1_empty: assert property (p_m1_empty) else $error("rx pin low when empty");
  property p_isr_top;
    s_rvalid && ar_q == 8'h04 |-> s_rdata[7:6] == {2{fc_q[0]}};
  endproperty
  a_isr_top: assert property (p_isr_top) else $error("status top bits wrong");
endmodule

bind uctl_top uctl_checker u_chk (
  .aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
  .s_wready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rvalid, .chan_src,
  .tx_fifo_clear, .rx_fifo_clear, .tx_ready_pin_chan_a, .rx_ready_pin_chan_a
);

// ==== dv/uctl_fifo_model.sv ====
`timescale 1ns/10ps
// ------
// FIFO and line logic model: holds the levels the bench asks for.
// ------
module uctl_fifo_model (
  // Clock and reset.
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // New source values, taken on load.
  input  wire logic                         load,
  input  wire uctl_pkg::uctl_src_type [1:0] want,
  // Clear pulses from the block.
  input  wire logic [1:0]                   tx_fifo_clear,
  input  wire logic [1:0]                   rx_fifo_clear,
  // Source lines towards the block.
  output uctl_pkg::uctl_src_type [1:0]      src
);
  import uctl_pkg::*;
  // A clear beats a load in the same cycle, as a real FIFO empties.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src <= '0;
    end else begin
      if (load) src <= want;
      for (int c = 0; c < 2; c++) begin
        if (tx_fifo_clear[c]) src[c].tx_count <= 8'h00;
        if (rx_fifo_clear[c]) src[c].rx_count <= 8'h00;
      end
    end
  end
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/10ps
module tb;
  import uctl_pkg::*;
  logic               aclk, aresetn, ld, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic               s_awready, s_wready, s_bvalid, s_arready, s_rvalid, txa, txb, rxa, rxb;
  logic [7:0]         s_awaddr, s_araddr;
  logic [31:0]        s_wdata, s_rdata;
  logic [3:0]         s_wstrb;
  logic [1:0]         s_bresp, s_rresp, txc, rxc;
  uctl_src_type [1:0] want, src;
  logic [33:0]        expq[$];
  int                 mismatches, checked, npulse;
  logic [7:0]         rxt[4] = '{8'h08, 8'h10, 8'h18, 8'h1c};
  logic [7:0]         txt[4] = '{8'h10, 8'h08, 8'h18, 8'h1e};

  uctl_top dut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .chan_src(src), .tx_fifo_clear(txc),
    .rx_fifo_clear(rxc), .tx_ready_pin_chan_a(txa), .tx_ready_pin_chan_b(txb),
    .rx_ready_pin_chan_a(rxa), .rx_ready_pin_chan_b(rxb));
  uctl_fifo_model u_fifo (.aclk, .aresetn, .load(ld), .want, .tx_fifo_clear(txc),
    .rx_fifo_clear(rxc), .src);

  // ------
  // Clock, checks and bus tasks.
  // ------
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic print_verdict();
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pins(input int c, input logic t, input logic r);
    chk({32'h0, c ? txb : txa, c ? rxb : rxa}, {32'h0, t, r});
  endtask
  // One load edge updates the sources; four edges let the pins settle.
  task automatic upd();
    @(posedge aclk) ld <= 1'b1;
    @(posedge aclk) ld <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= {24'h0, d};
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid);
    s_bready <= 1'b0;
    chk({32'h0, s_bresp}, 34'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    expq.push_back(e);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid);
    s_rready <= 1'b0;
  endtask
  // Each read answer meets the oldest noted expectation.
  always @(posedge aclk) begin
    if (s_rvalid && s_rready) chk({s_rresp, s_rdata}, expq.pop_front());
  end
  // Clear pulses of both channels are counted, so a missing or extra one shows.
  always @(posedge aclk) npulse <= npulse + $countones({txc, rxc});
  initial begin
    repeat (5000) @(posedge aclk);
    mismatches++;
    print_verdict();
  end

  // ------
  // Main sequence.
  // ------
  initial begin
    void'($urandom(2311));
    aresetn = 1'b0;
    {ld, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_wdata} = '0;
    s_wstrb = 4'h1;
    want = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 34'h0);
    rd(8'h04, 34'h1);
    rd(8'h20, {2'h2, 32'h0});
    rd(8'h44, 34'h1);
    for (int i = 0; i < 8; i++) begin
      want[i % 2].tx_count = i[1] ? 8'h00 : 8'($urandom_range(1, 32));
      want[i % 2].rx_count = i[2] ? 8'h00 : 8'($urandom_range(1, 32));
      upd();
      pins(i % 2, !i[1], i[2]);
    end
    wr(8'h00, 8'h01);
    want[0].xoff_rx = 1'b1;
    upd();
    want[0].xoff_rx = 1'b0;
    upd();
    rd(8'h04, 34'hc2);
    rd(8'h04, 34'hc1);
    want[0].xon_rx = 1'b1;
    upd();
    want[0] = '0;
    wr(8'h08, 8'h10);
    want[0].tx_count = 8'h05;
    upd();
    want[0] = '{rx_count: 8'h08, line_status_int: 1'b1, modem_status_int: 1'b1,
                xoff_rx: 1'b1, flow_change: 1'b1, default: '0};
    upd();
    want[0].xoff_rx = 1'b0;
    want[0].flow_change = 1'b0;
    upd();
    rd(8'h04, 34'hc6);
    want[0].line_status_int = 1'b0;
    upd();
    rd(8'h04, 34'hc4);
    want[0].line_status_int = 1'b1;
    upd();
    rd(8'h04, 34'hc4);
    want[0].line_status_int = 1'b0;
    want[0].rx_count = 8'h00;
    want[0].rx_timeout = 1'b1;
    upd();
    rd(8'h04, 34'hcc);
    want[0].rx_timeout = 1'b0;
    upd();
    rd(8'h04, 34'hc2);
    rd(8'h04, 34'hc0);
    want[0].modem_status_int = 1'b0;
    upd();
    rd(8'h04, 34'hd0);
    rd(8'h04, 34'hd0);
    want[0].xon_rx = 1'b1;
    upd();
    want[0].xon_rx = 1'b0;
    rd(8'h04, 34'he0);
    rd(8'h04, 34'hc1);
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, {k[1:0], k[1:0], 4'h9});
      want[0].rx_count = rxt[k] - 8'h01;
      want[0].tx_count = 8'h20;
      upd();
      pins(0, 1'b1, 1'b1);
      want[0].rx_count = rxt[k];
      want[0].tx_count = txt[k] + 8'h01;
      upd();
      pins(0, 1'b1, 1'b0);
      want[0].rx_count = 8'h01;
      want[0].tx_count = txt[k];
      upd();
      pins(0, 1'b0, 1'b0);
      want[0].rx_count = 8'h00;
      upd();
      pins(0, 1'b0, 1'b1);
    end
    want[0].rx_count = 8'h03;
    want[0].rx_timeout = 1'b1;
    upd();
    want[0].rx_timeout = 1'b0;
    upd();
    pins(0, 1'b0, 1'b0);
    want[0].rx_count = 8'h00;
    want[0].tx_count = 8'h20;
    upd();
    wr(8'h0c, 8'h03);
    wr(8'h10, 8'h1f);
    want[0].rx_count = 8'h03;
    want[0].tx_count = 8'h1f;
    upd();
    pins(0, 1'b0, 1'b0);
    npulse = 0;
    wr(8'h00, 8'h0f);
    repeat (4) @(posedge aclk);
    chk(34'(npulse), 34'h2);
    pins(0, 1'b0, 1'b1);
    rd(8'h00, 34'h09);
    wr(8'h00, 8'h09);
    wr(8'h40, 8'h06);
    repeat (4) @(posedge aclk);
    chk(34'(npulse), 34'h4);
    print_verdict();
  end
endmodule
